// *** shared/pbc_pkg.sv ***
package pbc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [11:0] PBC_OFS_HEADER   = 12'h20C;
  localparam logic [11:0] PBC_OFS_SELECTOR = 12'h210;
  localparam logic [11:0] PBC_OFS_DATA     = 12'h214;
  localparam logic [11:0] PBC_OFS_ALLOC    = 12'h218;
  // ==========================================================
  // header fields
  localparam logic [15:0] PBC_CAP_ID       = 16'h0004;
  localparam logic [3:0]  PBC_CAP_VER      = 4'h1;
  localparam logic [11:0] PBC_NEXT_UP      = 12'h230;
  localparam logic [11:0] PBC_NEXT_DOWN    = 12'h220;
  localparam int          PBC_ID_LSB       = 0;
  localparam int          PBC_VER_LSB      = 16;
  localparam int          PBC_NEXT_LSB     = 20;
  // ==========================================================
  // selector indices and reset
  localparam logic [7:0]  PBC_SEL_RST      = 8'h00;
  localparam logic [7:0]  PBC_SEL_D0_MAX   = 8'h00;
  localparam logic [7:0]  PBC_SEL_D0_SUST  = 8'h01;
  // ==========================================================
  // data word field positions
  localparam int          PBC_BASE_LSB     = 0;
  localparam int          PBC_SCALE_LSB    = 8;
  localparam int          PBC_SUB_LSB      = 10;
  localparam int          PBC_PMST_LSB     = 13;
  localparam int          PBC_TYPE_LSB     = 15;
  localparam int          PBC_RAIL_LSB     = 18;
  // ==========================================================
  // data word and alloc flag reset values
  localparam logic [7:0]  PBC_BASE_RST     = 8'h04;
  localparam logic [1:0]  PBC_SCALE_RST    = 2'h0;
  localparam logic [2:0]  PBC_SUB_RST      = 3'h0;
  localparam logic [1:0]  PBC_PMST_RST     = 2'h0;
  localparam logic [2:0]  PBC_TYPE_RST     = 3'h7;
  localparam logic [2:0]  PBC_RAIL_RST     = 3'h2;
  localparam logic        PBC_ALLOC_RST    = 1'b0;
  // ==========================================================
  // ahb encodings
  localparam logic [1:0]  PBC_HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0]  PBC_HSIZE_WORD   = 3'h2;
endpackage

// *** src/pbc_entry.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// override-able budget entry, loaded by sideband only
module pbc_entry
  import pbc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  // sideband load
  input  wire logic       load,
  input  wire logic [7:0] base_in,
  input  wire logic [1:0] scale_in,
  input  wire logic [1:0] pmst_in,
  // held values
  output logic      [7:0] base_q,
  output logic      [1:0] scale_q,
  output logic      [1:0] pmst_q
);
  // sideband is the only writer
  always_ff @(posedge clk) begin
    if (rst) begin
      base_q  <= PBC_BASE_RST;
      scale_q <= PBC_SCALE_RST;
      pmst_q  <= PBC_PMST_RST;
    end else if (load) begin
      base_q  <= base_in;
      scale_q <= scale_in;
      pmst_q  <= pmst_in;
    end
  end
endmodule
`default_nettype wire

// *** src/pbc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbc_regs
  import pbc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // port role strap, 1 = upstream port
  input  wire logic        UPSTREAM,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [11:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // sideband override (smbus, i2c, eeprom loader)
  input  wire logic        SB_LOAD,
  input  wire logic [7:0]  SB_BASE,
  input  wire logic [1:0]  SB_SCALE,
  input  wire logic [1:0]  SB_PMST,
  input  wire logic        SB_ALLOC,
  // state shown to the port
  output logic      [7:0]  SELECTOR,
  output logic             SYS_ALLOC
);
  // ==========================================================
  // declarations
  logic        act_q;
  logic        wr_q;
  logic [11:0] adr_q;
  logic [7:0]  sel_q;
  logic        alloc_q;
  logic        strap_q;
  logic [2:0]  strap_sync_q;
  logic [7:0]  base_v;
  logic [1:0]  scale_v;
  logic [1:0]  pmst_v;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        take;

  // ==========================================================
  // address decode helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // ==========================================================
  // sideband override storage
  pbc_entry u_entry (
    .clk      (CLK),
    .rst      (RST),
    .load     (SB_LOAD),
    .base_in  (SB_BASE),
    .scale_in (SB_SCALE),
    .pmst_in  (SB_PMST),
    .base_q   (base_v),
    .scale_q  (scale_v),
    .pmst_q   (pmst_v)
  );

  // allocated flag, sideband only
  always_ff @(posedge CLK) begin
    if (RST) begin
      alloc_q <= PBC_ALLOC_RST;
    end else if (SB_LOAD) begin
      alloc_q <= SB_ALLOC;
    end
  end

  // port role pin, three-stage sync, taken once stages two and three agree
  always_ff @(posedge CLK) begin
    strap_sync_q <= {strap_sync_q[1:0], UPSTREAM};
    if (strap_sync_q[1] == strap_sync_q[2]) begin
      strap_q <= strap_sync_q[2];
    end
  end

  // ==========================================================
  // ahb address phase capture
  assign take = HSEL && HREADY && (HTRANS == PBC_HTRANS_NSEQ);

  always_ff @(posedge CLK) begin
    if (RST) begin
      act_q <= 1'b0;
      wr_q  <= 1'b0;
      adr_q <= 12'h000;
    end else if (HREADY) begin
      act_q <= take;
      wr_q  <= take && HWRITE && (HSIZE == PBC_HSIZE_WORD);
      adr_q <= HADDR;
    end
  end

  // selector, the only software-writable field
  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_q <= PBC_SEL_RST;
    end else if (act_q && wr_q && hit(adr_q, PBC_OFS_SELECTOR)) begin
      sel_q <= HWDATA[7:0];
    end
  end

  // ==========================================================
  // read mux, evaluated at address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(HADDR, PBC_OFS_HEADER)) begin
      rdata_d[PBC_ID_LSB +: 16]  = PBC_CAP_ID;
      rdata_d[PBC_VER_LSB +: 4]  = PBC_CAP_VER;
      rdata_d[PBC_NEXT_LSB +: 12] = strap_q ? PBC_NEXT_UP : PBC_NEXT_DOWN;
    end else if (hit(HADDR, PBC_OFS_SELECTOR)) begin
      rdata_d[7:0] = sel_q;
    end else if (hit(HADDR, PBC_OFS_DATA)) begin
      if (sel_q == PBC_SEL_D0_MAX || sel_q == PBC_SEL_D0_SUST) begin
        rdata_d[PBC_BASE_LSB +: 8]  = base_v;
        rdata_d[PBC_SCALE_LSB +: 2] = scale_v;
        rdata_d[PBC_SUB_LSB +: 3]   = PBC_SUB_RST;
        rdata_d[PBC_PMST_LSB +: 2]  = pmst_v;
        rdata_d[PBC_TYPE_LSB +: 3]  = PBC_TYPE_RST;
        rdata_d[PBC_RAIL_LSB +: 3]  = PBC_RAIL_RST;
      end
    end else if (hit(HADDR, PBC_OFS_ALLOC)) begin
      rdata_d[0] = alloc_q;
    end
  end

  // read data register
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !HWRITE) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // outputs, zero wait state and always okay
  assign HRDATA    = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign SELECTOR  = sel_q;
  assign SYS_ALLOC = alloc_q;
endmodule
`default_nettype wire

// *** verif/pbc_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the budget register bank
module pbc_regs_bench
  import pbc_pkg::*;
;
  logic clk = 0, rst = 1, up = 1, hsel = 0, hwrite = 0, sb_load = 0, sb_alloc = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0, sb_scale = 0, sb_pmst = 0;
  logic [2:0]  hsize = PBC_HSIZE_WORD;
  logic [31:0] hwdata = 0, hrdata, r;
  logic [7:0]  sb_base = 8'h04, sel, selector;
  logic        hreadyout, hresp, sys_alloc;
  int          n_errors = 0, compares = 0, seed = 32'h861cb809;
  always #20 clk = ~clk;
  pbc_regs pbc_regs_inst (.CLK(clk), .RST(rst), .UPSTREAM(up), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SB_LOAD(sb_load), .SB_BASE(sb_base),
    .SB_SCALE(sb_scale), .SB_PMST(sb_pmst), .SB_ALLOC(sb_alloc), .SELECTOR(selector),
    .SYS_ALLOC(sys_alloc));
  // expected words
  function automatic logic [31:0] exp_hdr();
    return {up ? 12'h230 : 12'h220, 4'h1, 16'h0004};
  endfunction
  function automatic logic [31:0] exp_data(input logic [7:0] s);
    return s > 8'h01 ? 32'h0 : {11'h0, 3'h2, 3'h7, sb_pmst, 3'h0, sb_scale, sb_base};
  endfunction
  // one single ahb transfer, read data left in r
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PBC_HTRANS_NSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    compares++;
    if (r !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, r, exp);
      n_errors++;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic report_and_stop();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(PBC_OFS_HEADER, exp_hdr());
    rd(PBC_OFS_SELECTOR, 32'h0);
    rd(PBC_OFS_DATA, exp_data(8'h00));
    rd(PBC_OFS_ALLOC, 32'h0);
    for (int i = 0; i < 5; i++) xfer(1'b1, 12'h20C + 12'(4 * i), 32'hFFFFFF01);
    rd(PBC_OFS_HEADER, exp_hdr());
    rd(PBC_OFS_SELECTOR, 32'h1);
    hsize <= 3'h0;
    xfer(1'b1, PBC_OFS_SELECTOR, 32'h0000_0005);
    hsize <= PBC_HSIZE_WORD;
    rd(PBC_OFS_SELECTOR, 32'h1);
    chk({24'h0, selector}, 32'h1);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    rd(PBC_OFS_DATA, exp_data(8'h01));
    rd(PBC_OFS_ALLOC, 32'h0);
    rd(12'h21C, 32'h0);
    up <= 1'b0;
    repeat (6) @(posedge clk);
    rd(PBC_OFS_HEADER, exp_hdr());
    repeat (24) begin
      sel = 8'($random(seed));
      if (sel[7]) sel = {7'h0, sel[0]};
      xfer(1'b1, PBC_OFS_SELECTOR, {24'($random(seed)), sel});
      rd(PBC_OFS_SELECTOR, {24'h0, sel});
      {sb_alloc, sb_pmst, sb_scale, sb_base} <= 13'($random(seed));
      sb_load <= 1'b1;
      @(posedge clk);
      sb_load <= 1'b0;
      rd(PBC_OFS_DATA, exp_data(sel));
      rd(PBC_OFS_ALLOC, {31'h0, sb_alloc});
      chk({31'h0, sys_alloc}, {31'h0, sb_alloc});
    end
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verif/pbc_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus and sideband checks of the budget register bank
module pbc_regs_props
  import pbc_pkg::*;
(
  // watched ports
  input wire logic        CLK, RST, UPSTREAM, HSEL, HWRITE, HREADY, SB_LOAD, SB_ALLOC,
  input wire logic        SYS_ALLOC,
  input wire logic [11:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA, HRDATA,
  input wire logic [7:0]  SELECTOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic       take;
  logic       wr_q;
  logic       up_prev;
  logic [2:0] up_same;
  // cycles since the role pin last moved, saturating
  always_ff @(posedge CLK) begin
    up_prev <= UPSTREAM;
    if (RST || UPSTREAM != up_prev) begin
      up_same <= 3'h0;
    end else if (up_same != 3'h7) begin
      up_same <= up_same + 3'h1;
    end
  end
  // transfer accepted at this edge
  assign take = HSEL && HREADY && HTRANS == PBC_HTRANS_NSEQ;
  // selector write in its data phase
  always_ff @(posedge CLK) begin
    wr_q <= !RST && take && HWRITE && HSIZE == PBC_HSIZE_WORD && HADDR == PBC_OFS_SELECTOR;
  end
  sequence s_rd(a);
    take && !HWRITE && HADDR == a;
  endsequence
  a_sel_write: assert property (wr_q |=> SELECTOR == $past(HWDATA[7:0]))
    else $error("selector missed write");
  a_sel_hold: assert property (!wr_q |=> $stable(SELECTOR))
    else $error("selector changed");
  a_reset_values: assert property (disable iff (1'b0) RST |=> SELECTOR == 8'h00 && !SYS_ALLOC)
    else $error("bad reset value");
  a_hdr_read: assert property (s_rd(PBC_OFS_HEADER) ##0 up_same >= 3'h4 |=>
    HRDATA == {$past(UPSTREAM) ? 12'h230 : 12'h220, 4'h1, 16'h0004})
    else $error("bad header");
  a_data_fixed: assert property (s_rd(PBC_OFS_DATA) ##0 SELECTOR < 8'h02 |=>
    HRDATA[31:15] == {11'h0, 3'h2, 3'h7} && HRDATA[12:10] == 3'h0)
    else $error("bad fixed data");
  a_unsup_zero: assert property (s_rd(PBC_OFS_DATA) ##0 SELECTOR > 8'h01 |=> HRDATA == 32'h0)
    else $error("unsupported not zero");
  a_alloc_read: assert property (s_rd(PBC_OFS_ALLOC) |=> HRDATA == {31'h0, $past(SYS_ALLOC)})
    else $error("bad alloc read");
  a_sb_load: assert property (SB_LOAD |=> SYS_ALLOC == $past(SB_ALLOC))
    else $error("alloc not loaded");
  a_unmapped_zero: assert property (take && !HWRITE && HADDR[11:2] > PBC_OFS_ALLOC[11:2] |=> HRDATA == 0)
    else $error("unmapped not zero");
endmodule
bind pbc_regs pbc_regs_props pbc_regs_props_inst (.CLK(CLK), .RST(RST), .UPSTREAM(UPSTREAM),
  .HSEL(HSEL), .HWRITE(HWRITE), .HREADY(HREADY), .SB_LOAD(SB_LOAD), .SB_ALLOC(SB_ALLOC),
  .SYS_ALLOC(SYS_ALLOC), .HADDR(HADDR), .HTRANS(HTRANS), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HRDATA(HRDATA), .SELECTOR(SELECTOR));
`default_nettype wire
